// ===== include/rrn_pkg.sv
package rrn_pkg;
    localparam logic [5:0]  OPC_PATTERN      = 6'h10;
    localparam int          OPC_HI           = 15;
    localparam int          OPC_LO           = 10;
    localparam int          DEST_BIT         = 9;
    localparam int          ACC_BIT          = 8;
    localparam logic [7:0]  INDEX_LIMIT      = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
    localparam logic [3:0]  ACCESS_HI_BANK   = 4'hF;
    localparam logic [3:0]  ACCESS_LO_BANK   = 4'h0;
    localparam logic [7:0]  RESET_BYTE       = 8'h00;
    localparam logic [11:0] RESET_ADDR       = 12'h000;

    typedef enum logic [3:0] {
        RRN_Q1 = 4'b0001,
        RRN_Q2 = 4'b0010,
        RRN_Q3 = 4'b0100,
        RRN_Q4 = 4'b1000
    } rrn_phase_t;
endpackage : rrn_pkg

// ===== rtl/rrn_rotate.sv
`timescale 1ns/10ps
module rrn_rotate
    import rrn_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] operand,
    output logic      [WIDTH-1:0] result,
    output logic                  neg,
    output logic                  zero
);
    // Low bit wraps to the top, carry untouched
    assign result = {operand[0], operand[WIDTH-1:1]}; // RULE_01
    assign neg    = result[WIDTH-1];                  // RULE_05
    assign zero   = (result == '0);                   // RULE_05
endmodule : rrn_rotate

// ===== rtl/rrn_exec.sv
`timescale 1ns/10ps
// What this block does
// RULE_01 - Rotate operand right, bit 0 to bit 7
// RULE_02 - Destination bit: 0 to W, 1 back
// RULE_03 - Access bit: 0 access bank, 1 bank_selector
// RULE_04 - Extended set, access, f<=95: indexed offset
// RULE_05 - Decode 0100_00da, one cycle, N and Z
module rrn_exec
    import rrn_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [15:0] instr,
    input  wire logic [3:0]  bank_selector,
    input  wire logic        ext_set_en,
    input  wire logic [11:0] index_base,
    input  wire logic [7:0]  rd_data,
    output logic             busy,
    output logic             rd_en,
    output logic [11:0]      addr,
    output logic             wr_en,
    output logic [7:0]       wr_data,
    output logic             w_we,
    output logic [7:0]       w_data,
    output logic             flag_we,
    output logic             flag_n,
    output logic             flag_z,
    output logic             done
);
    rrn_phase_t phase;
    logic       dest_f;
    logic [7:0] operand;
    logic [7:0] rot;
    logic       rot_n;
    logic       rot_z;
    logic       take;

    function automatic logic is_rrn(input logic [15:0] word);
        is_rrn = (word[OPC_HI:OPC_LO] == OPC_PATTERN);
    endfunction : is_rrn

    function automatic logic [11:0] resolve(input logic [15:0] word,
                                            input logic [3:0]  bank,
                                            input logic        ext,
                                            input logic [11:0] base);
        logic [7:0] f;
        f = word[7:0];
        if (word[ACC_BIT]) begin
            resolve = {bank, f}; // RULE_03
        end else if (ext && f <= INDEX_LIMIT) begin
            resolve = 12'(base + {4'h0, f}); // RULE_04
        end else if (f < ACCESS_SPLIT) begin
            resolve = {ACCESS_LO_BANK, f}; // RULE_03
        end else begin
            resolve = {ACCESS_HI_BANK, f}; // RULE_03
        end
    endfunction : resolve

    rrn_rotate #(
        .WIDTH(8)
    ) u_rot (
        .operand(operand),
        .result (rot),
        .neg    (rot_n),
        .zero   (rot_z)
    );

    // Four phases make one instruction cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= RRN_Q1;
        end else begin
            case (phase)
                RRN_Q1: if (take) phase <= RRN_Q2; // RULE_05
                RRN_Q2: phase <= RRN_Q3;
                RRN_Q3: phase <= RRN_Q4;
                RRN_Q4: phase <= RRN_Q1;
                default: phase <= RRN_Q1;
            endcase
        end
    end

    // Address latched at decode; bank_selector may change afterwards
    always_ff @(posedge clk) begin
        if (rst) begin
            addr   <= RESET_ADDR;
            dest_f <= 1'b1;
        end else if (take) begin
            addr   <= resolve(instr, bank_selector, ext_set_en, index_base);
            dest_f <= instr[DEST_BIT];
        end
    end

    // Latched at end of Q2, so the file may change after the read
    always_ff @(posedge clk) begin
        if (rst) begin
            operand <= RESET_BYTE;
        end else if (phase == RRN_Q2) begin
            operand <= rd_data;
        end
    end

    // Registered in Q3 so data, flags and strobes leave together
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_data <= RESET_BYTE;
            w_data  <= RESET_BYTE;
            flag_n  <= 1'b0;
            flag_z  <= 1'b0;
        end else if (phase == RRN_Q3) begin
            wr_data <= rot;   // RULE_01
            w_data  <= rot;
            flag_n  <= rot_n; // RULE_05
            flag_z  <= rot_z;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_en   <= 1'b0;
            w_we    <= 1'b0;
            flag_we <= 1'b0;
            done    <= 1'b0;
        end else begin
            wr_en   <= (phase == RRN_Q3) && dest_f;  // RULE_02
            w_we    <= (phase == RRN_Q3) && !dest_f; // RULE_02
            flag_we <= (phase == RRN_Q3);            // RULE_05
            done    <= (phase == RRN_Q3);
        end
    end

    assign busy  = (phase != RRN_Q1);
    assign rd_en = (phase == RRN_Q2);

    // Accepted only in Q1; a start during Q2..Q4 is dropped
    assign take = (phase == RRN_Q1) && start && is_rrn(instr);

    AST_ROT_VALUE: assert property (@(posedge clk) disable iff (rst) // RULE_01
        rd_en |-> ##2 wr_data == {$past(rd_data[0], 2), $past(rd_data[7:1], 2)})
        else $error("rotated value wrong");

    AST_DEST_F: assert property (@(posedge clk) disable iff (rst) // RULE_02
        wr_en |-> dest_f && !w_we)
        else $error("file write without dest bit");

    AST_DEST_W: assert property (@(posedge clk) disable iff (rst) // RULE_02
        w_we |-> !dest_f && !wr_en)
        else $error("W write with dest bit");

    // One destination per instruction, never both and never none
    AST_ONE_DEST: assert property (@(posedge clk) disable iff (rst) // RULE_02
        done |-> wr_en != w_we)
        else $error("destination strobes not exclusive");

    AST_WRITE_BACK: assert property (@(posedge clk) disable iff (rst) // RULE_02
        rd_en ##2 wr_en |-> addr == $past(addr, 2))
        else $error("file write went to another register");

    AST_BANKED: assert property (@(posedge clk) disable iff (rst) // RULE_03
        take && instr[ACC_BIT]
        |=> addr == {$past(bank_selector), $past(instr[7:0])})
        else $error("banked address wrong");

    AST_ACCESS: assert property (@(posedge clk) disable iff (rst) // RULE_03
        take && !instr[ACC_BIT] && !ext_set_en
        |=> addr[7:0] == $past(instr[7:0])
            && addr[11:8] == ($past(instr[7:0]) >= ACCESS_SPLIT
                              ? ACCESS_HI_BANK : ACCESS_LO_BANK))
        else $error("access bank address wrong");

    AST_ADDR_STEADY: assert property (@(posedge clk) disable iff (rst) // RULE_03
        busy && !rd_en |-> $stable(addr))
        else $error("address moved during instruction");

    AST_INDEXED: assert property (@(posedge clk) disable iff (rst) // RULE_04
        take && !instr[ACC_BIT] && ext_set_en && instr[7:0] <= INDEX_LIMIT
        |=> addr == 12'($past(index_base) + {4'h0, $past(instr[7:0])}))
        else $error("indexed address wrong");

    // Above the offset window the access bank applies as usual
    AST_ACCESS_EXT: assert property (@(posedge clk) disable iff (rst) // RULE_04
        take && !instr[ACC_BIT] && ext_set_en && instr[7:0] > INDEX_LIMIT
        |=> addr == {ACCESS_HI_BANK, $past(instr[7:0])})
        else $error("offset mode used above its window");

    AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst) // RULE_05
        take |-> ##3 done ##1 !done)
        else $error("instruction not done in four phases");

    AST_BUSY_SPAN: assert property (@(posedge clk) disable iff (rst) // RULE_05
        take |=> busy [*3] ##1 !busy)
        else $error("busy span wrong");

    AST_READ_PULSE: assert property (@(posedge clk) disable iff (rst) // RULE_05
        take |=> rd_en ##1 !rd_en)
        else $error("operand read not a single Q2 pulse");

    // A start during Q2..Q4 must not restart the read
    AST_IGNORE_BUSY: assert property (@(posedge clk) disable iff (rst) // RULE_05
        busy |=> !rd_en)
        else $error("start taken while busy");

    AST_FLAGS: assert property (@(posedge clk) disable iff (rst) // RULE_05
        flag_we |-> flag_z == (wr_data == 8'h00) && flag_n == wr_data[7])
        else $error("flags disagree with result");

    AST_FLAG_EACH: assert property (@(posedge clk) disable iff (rst) // RULE_05
        done |-> flag_we)
        else $error("completion without flag update");

    AST_NZ_EXCL: assert property (@(posedge clk) disable iff (rst) // RULE_05
        flag_we && flag_z |-> !flag_n)
        else $error("zero result flagged negative");

    AST_NO_DECODE: assert property (@(posedge clk) disable iff (rst) // RULE_05
        !busy && !take |=> !busy)
        else $error("foreign opcode started");

    COV_TO_FILE: cover property (@(posedge clk) disable iff (rst) wr_en);
    COV_TO_W: cover property (@(posedge clk) disable iff (rst) w_we);
    COV_INDEXED: cover property (@(posedge clk) disable iff (rst)
        take && !instr[ACC_BIT] && ext_set_en);
    COV_ZERO: cover property (@(posedge clk) disable iff (rst) flag_we && flag_z);
    COV_BUSY_START: cover property (@(posedge clk) disable iff (rst) busy && start && is_rrn(instr));
endmodule : rrn_exec

// ===== tb/rrn_regfile.sv
`timescale 1ns/10ps
module rrn_regfile (
    input  wire logic        clk,
    input  wire logic        rd_en,
    input  wire logic [11:0] addr,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data
);
    logic [7:0] mem [0:4095];
    logic [7:0] junk = 8'h3C;
    // Churns off-cycle so a late sample never sees a stale byte
    assign rd_data = rd_en ? mem[addr] : junk;
    always @(posedge clk) begin
        junk <= junk + 8'h53;
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end
endmodule : rrn_regfile

// ===== tb/rotate_right_no_carry_exec_tb.sv
`timescale 1ns/10ps
module rotate_right_no_carry_exec_tb;
    import rrn_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, start = 1'b0, ext_set_en = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [3:0]  bank_selector = 4'h0;
    logic [11:0] index_base = 12'h000, addr;
    logic [7:0]  rd_data, wr_data, w_data;
    logic        busy, rd_en, wr_en, w_we, flag_we, flag_n, flag_z, done;
    int          n_mismatch = 0, samples_checked = 0;
    always #5 clk = ~clk;
    rrn_exec dut_u (.clk, .rst, .start, .instr, .bank_selector, .ext_set_en, .index_base,
        .rd_data, .busy, .rd_en, .addr, .wr_en, .wr_data, .w_we, .w_data, .flag_we,
        .flag_n, .flag_z, .done);
    rrn_regfile rf_u (.clk, .rd_en, .addr, .wr_en, .wr_data, .rd_data);
    task automatic chk(input bit ok, input string what);
        samples_checked++;
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] t=%0t %s", $time, what);
        end
    endtask : chk
    task automatic run_op(input bit d, input bit a, input logic [7:0] f, input logic [7:0] v,
        input logic [3:0] bank, input bit ext, input logic [11:0] base, input logic [11:0] ea);
        logic [7:0] r;
        r = {v[0], v[7:1]};
        rf_u.mem[ea] = v;
        @(posedge clk);
        start <= 1'b1;
        instr <= {OPC_PATTERN, d, a, f};
        bank_selector <= bank;
        ext_set_en <= ext;
        index_base <= base;
        @(posedge clk);
        start <= 1'b0;
        #1;
        chk(rd_en === 1'b1 && busy === 1'b1 && addr === ea, "operand address");
        repeat (2) @(posedge clk);
        #1;
        chk(done === 1'b1 && flag_we === 1'b1, "completion cycle");
        chk(wr_en === d && w_we === !d, "destination strobe");
        chk((d ? wr_data : w_data) === r, "rotated value");
        chk(flag_n === r[7] && flag_z === (r == 8'h00), "flags");
        @(posedge clk);
        #1;
        chk(rf_u.mem[ea] === (d ? r : v), "write back");
        chk(done === 1'b0 && wr_en === 1'b0 && w_we === 1'b0 && busy === 1'b0, "strobe width");
    endtask : run_op
    task automatic sc_banked;
        run_op(1, 1, 8'h22, 8'hD7, 4'h3, 0, 12'h000, 12'h322);
    endtask : sc_banked
    task automatic sc_access;
        run_op(0, 0, 8'h70, 8'h01, 4'h5, 0, 12'h000, 12'hF70);
        run_op(1, 0, 8'h10, 8'h00, 4'h5, 0, 12'h000, 12'h010);
    endtask : sc_access
    task automatic sc_indexed;
        run_op(0, 0, 8'h5F, 8'h80, 4'h2, 1, 12'h200, 12'h25F);
        run_op(1, 0, 8'h60, 8'h3C, 4'h2, 1, 12'h200, 12'hF60);
        run_op(0, 1, 8'h05, 8'hAA, 4'h7, 1, 12'h200, 12'h705);
    endtask : sc_indexed
    task automatic sc_busy_start;
        rf_u.mem[12'h344] = 8'h02;
        rf_u.mem[12'h355] = 8'h04;
        @(posedge clk);
        start <= 1'b1;
        instr <= {OPC_PATTERN, 1'b1, 1'b1, 8'h44};
        bank_selector <= 4'h3;
        ext_set_en <= 1'b0;
        @(posedge clk);
        instr <= {OPC_PATTERN, 1'b1, 1'b1, 8'h55};
        repeat (2) @(posedge clk);
        start <= 1'b0;
        #1;
        chk(done === 1'b1 && wr_en === 1'b1 && addr === 12'h344, "start while busy");
        chk(wr_data === 8'h01, "first operand kept");
        repeat (2) @(posedge clk);
        #1;
        chk(busy === 1'b0 && rf_u.mem[12'h355] === 8'h04, "second start ignored");
    endtask : sc_busy_start
    task automatic sc_refused;
        @(posedge clk);
        start <= 1'b1;
        instr <= 16'h4422;
        repeat (3) @(posedge clk);
        #1;
        chk(busy === 1'b0 && rd_en === 1'b0 && done === 1'b0, "foreign opcode");
        @(posedge clk);
        start <= 1'b0;
    endtask : sc_refused
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        sc_banked();
        sc_access();
        sc_indexed();
        sc_busy_start();
        sc_refused();
        report_and_stop();
    end
endmodule : rotate_right_no_carry_exec_tb
